// ### bench/dscp_ctrl_model.sv
// Controller model that drives the profile, commit and parallel pins on the quarter-rate clock
`timescale 1ns/1ps
module dscp_ctrl_model (
   input  wire logic        i_sync_clk,
   output logic      [2:0]  o_profile_sel,
   output logic             o_commit,
   output logic             o_burst_valid,
   output logic      [15:0] o_par_data,
   output logic      [1:0]  o_fmt_sel
);
   // ****************************************
   // Pin drivers
   // ****************************************
   // Quiet pins at time zero
   initial begin
      o_profile_sel = 3'h0;
      o_commit      = 1'b0;
      o_burst_valid = 1'b0;
      o_par_data    = 16'h0000;
      o_fmt_sel     = 2'h0;
   end

   // Changes land just after the quarter-rate rising edge, a full period of setup
   task automatic set_profile(input logic [2:0] p);
      @(posedge i_sync_clk);
      o_profile_sel <= p;
   endtask

   // Commit held for one quarter-rate period
   task automatic commit();
      @(posedge i_sync_clk);
      o_commit <= 1'b1;
      @(posedge i_sync_clk);
      o_commit <= 1'b0;
   endtask

   // One burst word; afterwards the bus shows junk so stale data never passes
   task automatic send(input logic [1:0] f, input logic [15:0] d);
      @(posedge i_sync_clk);
      o_burst_valid <= 1'b1;
      o_par_data    <= d;
      o_fmt_sel     <= f;
      @(posedge i_sync_clk);
      o_burst_valid <= 1'b0;
      o_par_data    <= ~d;
      o_fmt_sel     <= ~f;
   endtask
endmodule

// ### bench/tb_top.sv
// Self-checking bench of the synthesizer control-pin logic
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin num_errors++; \
   $display("unexpected %s expected %0h seen %0h", nm, exp, got); end end
module tb_top;
   localparam int WIN = 8;   // Short sync window keeps the run brief
   logic clk = 1'b0, rst = 1'b1, wr_s, rd_s, pdreq, lock, sweep, sync_in, sclk, pclk, sop, son;
   logic fault, locked, sdone, pdact, bvalid, commit;
   logic [7:0]  addr;
   logic [31:0] wdata, rdata, pword;
   logic [2:0]  prof;
   logic [15:0] pdata;
   logic [1:0]  fmt, pdmode;
   logic [6:0]  mult;
   dscp_pkg::dscp_mod_word_t mword;
   int num_errors = 0, samples_checked = 0;

   always #5 clk = ~clk;

   dscp_top #(.SYNC_WINDOW(WIN)) u_dut (.i_clk_sys(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata), .i_profile_sel(prof), .i_commit(commit),
      .i_external_powerdown_req(pdreq), .i_pll_lock_det(lock), .i_ram_sweep_end(sweep),
      .i_sync_in_p(sync_in), .i_burst_valid(bvalid), .i_par_data(pdata), .i_fmt_sel(fmt),
      .o_sync_clk(sclk), .o_parallel_data_clock(pclk), .o_sync_out_p(sop), .o_sync_out_n(son),
      .o_sync_sample_fault(fault), .o_pll_locked(locked), .o_ram_sweep_done(sdone),
      .o_powerdown_active(pdact), .o_powerdown_mode(pdmode), .o_system_clock_mult(mult),
      .o_profile_word(pword), .o_mod_word(mword));

   dscp_ctrl_model u_ctrl (.i_sync_clk(sclk), .o_profile_sel(prof), .o_commit(commit),
      .o_burst_valid(bvalid), .o_par_data(pdata), .o_fmt_sel(fmt));

   // ****************************************
   // Bus tasks and closing
   // ****************************************
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr_s  <= 1'b1;
      @(posedge clk);
      wr_s  <= 1'b0;
   endtask

   // Read data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1 d = rdata;
   endtask

   task automatic complete_run();
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // Watchdog well beyond the few hundred cycles the sequence needs
   initial begin
      #100000;
      num_errors++;
      complete_run();
   end

   // ****************************************
   // Test sequence
   // ****************************************
   initial begin
      logic [31:0] d;
      logic        prev;
      int          cnt;
      {addr, wdata, wr_s, rd_s, pdreq, lock, sweep, sync_in} = '0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      #1;
      `CHK("sync out n", 1'b1, son)
      `CHK("profile word", 32'h0, pword)
      rd(dscp_pkg::ADDR_CFG, d);
      `CHK("cfg", dscp_pkg::CFG_RST, d)
      // Quarter-rate clock: four rises in sixteen cycles, data clock identical
      cnt  = 0;
      prev = sclk;
      repeat (16) begin
         tick(1);
         cnt += int'(sclk & ~prev);
         prev = sclk;
         `CHK("data clock", sclk, pclk)
      end
      `CHK("sync clock rises", 4, cnt)
      // Lock and sweep status, pins and register view
      @(posedge clk) lock <= 1'b1;
      sweep <= 1'b1;
      @(posedge clk) sweep <= 1'b0;
      tick(3);
      `CHK("pll locked", 1'b1, locked)
      `CHK("sweep done", 1'b1, sdone)
      rd(dscp_pkg::ADDR_STATUS, d);
      `CHK("status lock sweep", 2'h3, d[8:7])
      // Stage all eight profiles, then walk the select through all of them and back to 0
      for (int n = 0; n < 8; n++)
         wr(dscp_pkg::ADDR_PROF_LO + 8'(n << dscp_pkg::PROF_IDX_LSB), 32'hC0DE_0000 + 32'(n));
      for (int n = 1; n <= 8; n++) begin
         u_ctrl.set_profile(3'(n));
         tick(4);
         `CHK("profile word", 32'hC0DE_0000 + 32'(n % 8), pword)
      end
      `CHK("sweep done cleared", 1'b0, sdone)
      // Staged words stay hidden until commit
      wr(dscp_pkg::ADDR_PROF_LO, 32'h1234_5678);
      wr(dscp_pkg::ADDR_CFG, 32'h0000_00BE);
      tick(4);
      `CHK("before commit", 32'hC0DE_0000, pword)
      u_ctrl.commit();
      tick(4);
      `CHK("after commit", 32'h1234_5678, pword)
      `CHK("clock mult", 7'h05, mult)
      // Sync output: one pulse in four cycles, negative leg inverted
      cnt = 0;
      repeat (8) begin
         tick(1);
         cnt += int'(sop);
         `CHK("sync out n", ~sop, son)
      end
      `CHK("sync pulses", 2, cnt)
      @(posedge clk) pdreq <= 1'b1;
      tick(4);
      `CHK("pd active", 1'b1, pdact)
      `CHK("pd mode", 2'h2, pdmode)
      @(posedge clk) pdreq <= 1'b0;
      tick(4);
      `CHK("pd released", 1'b0, pdact)
      // No sync edge for longer than the window, then one edge clears the fault
      `CHK("sync fault", 1'b1, fault)
      @(posedge clk) sync_in <= 1'b1;
      @(posedge clk) sync_in <= 1'b0;
      tick(3);
      `CHK("sync fault cleared", 1'b0, fault)
      // Every format code through the parallel port
      for (int f = 0; f < 4; f++) begin
         fork
            u_ctrl.send(2'(f), 16'hA5C0 + 16'(f));
            begin
               cnt = 0;
               do begin
                  tick(1);
                  cnt++;
               end while (mword.valid !== 1'b1 && cnt < 12);
               `CHK("mod data", 16'hA5C0 + 16'(f), mword.data)
               `CHK("mod dest", dscp_pkg::dscp_dest_t'(f), mword.dest)
               `CHK("mod fmt", 2'(f), mword.fmt)
               tick(1);
               `CHK("mod valid pulse", 1'b0, mword.valid)
            end
         join
      end
      // Second reset in mid-run restores defaults
      @(posedge clk) rst <= 1'b1;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      tick(2);
      `CHK("profile word", 32'h0, pword)
      `CHK("clock mult", 7'h01, mult)
      rd(dscp_pkg::ADDR_PROF_LO + 8'h0C, d);
      `CHK("staged word", dscp_pkg::PROF_RST, d)
      rd(8'h10, d);
      `CHK("unmapped read", 32'h0, d)
      complete_run();
   end
endmodule

// ### rtl/dscp_pkg.sv
// Shared constants, field layouts and carriers of the synthesizer control-pin logic
package dscp_pkg;

   // ****************************************
   // Register map (byte addresses)
   // ****************************************
   localparam logic [7:0] ADDR_CFG      = 8'h00;
   localparam logic [7:0] ADDR_STATUS   = 8'h04;
   localparam logic [7:0] ADDR_PROF_LO  = 8'h20;   // Eight profile words, 0x20..0x3C
   localparam logic [7:0] ADDR_PROF_HI  = 8'h3C;
   localparam int         PROF_IDX_LSB  = 2;
   localparam int         PROF_COUNT    = 8;

   // ****************************************
   // Reset values and timing counts
   // ****************************************
   localparam logic [31:0] CFG_RST       = 32'h0000_0020;  // Multiplier factor 1, all else off
   localparam logic [31:0] PROF_RST      = 32'h0000_0000;
   localparam logic [1:0]  SUB_RST       = 2'h0;
   localparam logic [1:0]  SUB_ALIGN     = 2'h0;            // Subclock phase forced on a sync edge
   localparam logic [1:0]  CAPTURE_PHASE = 2'h3;            // Parallel word taken as the data clock falls
   localparam int          SYNC_WINDOW   = 16;              // Cycles allowed between sync edges

   // ****************************************
   // Field layouts and carriers
   // ****************************************
   typedef struct packed {
      logic [19:0] rsvd;
      logic [6:0]  ref_mult_factor;
      logic        ref_mult_en;
      logic        sync_tx_en;
      logic        sync_rx_en;
      logic [1:0]  pd_mode;
   } dscp_cfg_t;

   typedef struct packed {
      logic [20:0] rsvd;
      logic        powerdown_active;
      logic        sync_sample_fault;
      logic        ram_sweep_done;
      logic        pll_locked;
      logic [2:0]  profile;
      logic [3:0]  dummy;
   } dscp_status_t;

   typedef enum logic [1:0] {
      DSCP_DEST_AMPL,
      DSCP_DEST_PHASE,
      DSCP_DEST_FREQ,
      DSCP_DEST_POLAR
   } dscp_dest_t;

   typedef struct packed {
      logic        valid;
      dscp_dest_t  dest;
      logic [1:0]  fmt;
      logic [15:0] data;
   } dscp_mod_word_t;

endpackage

// ### rtl/dscp_top.sv
// Control-pin logic of the synthesizer: profiles, buffer commit, sync clocks, status and parallel port
//
// What this block does
// - Three-bit profile select picks one of eight stored profiles for the core.
// - Any profile select change copies all staging buffers into active registers.
// - Output a sync clock at one quarter of the system clock.
// - Full reset input clears all storage and restores register defaults.
// - External power-down request enters the programmed power-down mode.
// - Multiplier-locked output high when the clock multiplier PLL is locked.
// - RAM sweep done output high once the current sweep has finished.
// - Sync sample fault output high when no valid sync is captured.
// - Align internal subclocks to rising edges of the incoming sync signal.
// - Drive a rising-edge-active differential sync output from the subclocks.
// - Output a parallel data clock as timing reference for parallel words.
// - Parallel port carries a sixteen-bit active-high word, bits 15 down to 0.
// - Two-bit format input decides how each parallel word is applied.
// - High on commit input moves all staged buffers into internal registers.
// - System clock ratio is the multiplier factor when used, otherwise one.
//
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
module dscp_top #(
   parameter int SYNC_WINDOW = dscp_pkg::SYNC_WINDOW
) (
   input  wire logic                     i_clk_sys,
   input  wire logic                     i_rst,
   // Register port
   input  wire logic [7:0]               i_addr,
   input  wire logic [31:0]              i_wdata,
   input  wire logic                     i_wr,
   input  wire logic                     i_rd,
   output logic      [31:0]              o_rdata,
   // Control pins
   input  wire logic [2:0]               i_profile_sel,
   input  wire logic                     i_commit,
   input  wire logic                     i_external_powerdown_req,
   input  wire logic                     i_pll_lock_det,
   input  wire logic                     i_ram_sweep_end,
   input  wire logic                     i_sync_in_p,
   input  wire logic                     i_burst_valid,
   input  wire logic [15:0]              i_par_data,
   input  wire logic [1:0]               i_fmt_sel,
   // Outputs
   output logic                          o_sync_clk,
   output logic                          o_parallel_data_clock,
   output logic                          o_sync_out_p,
   output logic                          o_sync_out_n,
   output logic                          o_sync_sample_fault,
   output logic                          o_pll_locked,
   output logic                          o_ram_sweep_done,
   output logic                          o_powerdown_active,
   output logic      [1:0]               o_powerdown_mode,
   output logic      [6:0]               o_system_clock_mult,
   output logic      [31:0]              o_profile_word,
   output dscp_pkg::dscp_mod_word_t      o_mod_word
);

   // ****************************************
   // Types and decode helpers
   // ****************************************
   typedef enum logic [1:0] {
      SYNC_OFF,
      SYNC_WAIT,
      SYNC_GOOD,
      SYNC_FAULT
   } dscp_sync_state_t;

   localparam logic [7:0] WIN_LAST = 8'(SYNC_WINDOW - 1);

   // Profile slot decode, shared by write and read paths
   function automatic logic is_prof_addr(input logic [7:0] a);
      is_prof_addr = (a >= dscp_pkg::ADDR_PROF_LO) && (a <= dscp_pkg::ADDR_PROF_HI) && (a[1:0] == 2'h0);
   endfunction

   function automatic dscp_pkg::dscp_dest_t fmt_dest(input logic [1:0] f);
      case (f)
         2'h0:    fmt_dest = dscp_pkg::DSCP_DEST_AMPL;
         2'h1:    fmt_dest = dscp_pkg::DSCP_DEST_PHASE;
         2'h2:    fmt_dest = dscp_pkg::DSCP_DEST_FREQ;
         default: fmt_dest = dscp_pkg::DSCP_DEST_POLAR;
      endcase
   endfunction

   // ****************************************
   // Input registers
   // ****************************************
   logic [2:0]          prof_q_reg;
   logic [2:0]          prof_prev_reg;
   logic                commit_q_reg;
   logic                commit_prev_reg;
   logic                pd_q_reg;
   logic                pll_q_reg;
   logic                ram_end_q_reg;
   logic                sync_q_reg;
   logic                sync_prev_reg;
   logic                bv_q_reg;
   logic [15:0]         data_q_reg;
   logic [1:0]          fmt_q_reg;

   // Every control pin is taken once so change detection sees one stable copy; the register port is used unregistered
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         prof_q_reg      <= 3'h0;
         prof_prev_reg   <= 3'h0;
         commit_q_reg    <= 1'b0;
         commit_prev_reg <= 1'b0;
         pd_q_reg        <= 1'b0;
         pll_q_reg       <= 1'b0;
         ram_end_q_reg   <= 1'b0;
         sync_q_reg      <= 1'b0;
         sync_prev_reg   <= 1'b0;
         bv_q_reg        <= 1'b0;
         data_q_reg      <= 16'h0000;
         fmt_q_reg       <= 2'h0;
      end else begin
         prof_q_reg      <= i_profile_sel;
         prof_prev_reg   <= prof_q_reg;
         commit_q_reg    <= i_commit;
         commit_prev_reg <= commit_q_reg;
         pd_q_reg        <= i_external_powerdown_req;
         pll_q_reg       <= i_pll_lock_det;
         ram_end_q_reg   <= i_ram_sweep_end;
         sync_q_reg      <= i_sync_in_p;
         sync_prev_reg   <= sync_q_reg;
         bv_q_reg        <= i_burst_valid;
         data_q_reg      <= i_par_data;
         fmt_q_reg       <= i_fmt_sel;
      end
   end

   logic prof_change;
   logic commit_rise;
   logic xfer;
   logic sync_rise;

   assign prof_change = (prof_q_reg != prof_prev_reg);
   // Level high commits once on its leading edge; holding it high adds nothing
   assign commit_rise = commit_q_reg & ~commit_prev_reg;
   assign xfer        = prof_change | commit_rise;
   assign sync_rise   = sync_q_reg & ~sync_prev_reg;

   // ****************************************
   // Staging buffers and active registers
   // ****************************************
   dscp_pkg::dscp_cfg_t cfg_stg_reg;
   dscp_pkg::dscp_cfg_t cfg_act_reg;
   logic [31:0]         prof_stg_reg [dscp_pkg::PROF_COUNT];
   logic [31:0]         prof_act_reg [dscp_pkg::PROF_COUNT];

   // Software writes land only in the staging copy; the core never sees half an update
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         cfg_stg_reg <= dscp_pkg::CFG_RST;
      end else if (i_wr && (i_addr == dscp_pkg::ADDR_CFG)) begin
         cfg_stg_reg <= i_wdata;
      end
   end

   // All staged contents move together on a profile change or a commit
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         cfg_act_reg <= dscp_pkg::CFG_RST;
      end else if (xfer) begin
         cfg_act_reg <= cfg_stg_reg;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < dscp_pkg::PROF_COUNT; gi++) begin : g_prof
         always_ff @(posedge i_clk_sys) begin
            if (i_rst) begin
               prof_stg_reg[gi] <= dscp_pkg::PROF_RST;
               prof_act_reg[gi] <= dscp_pkg::PROF_RST;
            end else begin
               if (i_wr && is_prof_addr(i_addr) && (i_addr[4:2] == 3'(gi))) begin
                  prof_stg_reg[gi] <= i_wdata;
               end
               if (xfer) begin
                  prof_act_reg[gi] <= prof_stg_reg[gi];
               end
            end
         end
      end
   endgenerate

   // Selected profile word for the synthesis core
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_profile_word <= dscp_pkg::PROF_RST;
      end else begin
         o_profile_word <= prof_act_reg[prof_q_reg];
      end
   end

   // ****************************************
   // Subclock, sync clock and sync output
   // ****************************************
   logic [1:0] sub_cnt_reg;

   // A sync edge restarts the divider so every slave shares one phase
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         sub_cnt_reg <= dscp_pkg::SUB_RST;
      end else if (cfg_act_reg.sync_rx_en && sync_rise) begin
         sub_cnt_reg <= dscp_pkg::SUB_ALIGN;
      end else begin
         sub_cnt_reg <= sub_cnt_reg + 2'h1;
      end
   end

   assign o_sync_clk            = sub_cnt_reg[1];
   assign o_parallel_data_clock = sub_cnt_reg[1];

   // Sync out pulses once per subclock period; complement kept as the differential half
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_sync_out_p <= 1'b0;
         o_sync_out_n <= 1'b1;
      end else begin
         o_sync_out_p <= cfg_act_reg.sync_tx_en && (sub_cnt_reg == 2'h0);
         o_sync_out_n <= !(cfg_act_reg.sync_tx_en && (sub_cnt_reg == 2'h0));
      end
   end

   // ****************************************
   // Sync sample supervision
   // ****************************************
   dscp_sync_state_t sync_st_reg;
   logic [7:0]       win_cnt_reg;

   // A missing edge within the window counts as a failed sample; the next edge recovers
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         sync_st_reg <= SYNC_OFF;
         win_cnt_reg <= 8'h00;
      end else begin
         case (sync_st_reg)
            SYNC_OFF: begin
               win_cnt_reg <= 8'h00;
               if (cfg_act_reg.sync_rx_en) begin
                  sync_st_reg <= SYNC_WAIT;
               end
            end
            SYNC_WAIT, SYNC_GOOD: begin
               if (!cfg_act_reg.sync_rx_en) begin
                  sync_st_reg <= SYNC_OFF;
               end else if (sync_rise) begin
                  sync_st_reg <= SYNC_GOOD;
                  win_cnt_reg <= 8'h00;
               end else if (win_cnt_reg == WIN_LAST) begin
                  sync_st_reg <= SYNC_FAULT;
               end else begin
                  win_cnt_reg <= win_cnt_reg + 8'h01;
               end
            end
            SYNC_FAULT: begin
               win_cnt_reg <= 8'h00;
               if (!cfg_act_reg.sync_rx_en) begin
                  sync_st_reg <= SYNC_OFF;
               end else if (sync_rise) begin
                  sync_st_reg <= SYNC_GOOD;
               end
            end
            default: sync_st_reg <= SYNC_OFF;
         endcase
      end
   end

   // ****************************************
   // Status, power-down and clock ratio
   // ****************************************
   // Sweep done clears on a new profile; an end arriving in that cycle still wins
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_ram_sweep_done <= 1'b0;
      end else if (ram_end_q_reg) begin
         o_ram_sweep_done <= 1'b1;
      end else if (prof_change) begin
         o_ram_sweep_done <= 1'b0;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_pll_locked        <= 1'b0;
         o_sync_sample_fault <= 1'b0;
      end else begin
         o_pll_locked        <= pll_q_reg;
         o_sync_sample_fault <= (sync_st_reg == SYNC_FAULT);
      end
   end

   // The pin picks the moment, software picks the depth of power-down
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_powerdown_active <= 1'b0;
         o_powerdown_mode   <= 2'h0;
      end else begin
         o_powerdown_active <= pd_q_reg;
         o_powerdown_mode   <= pd_q_reg ? cfg_act_reg.pd_mode : 2'h0;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_system_clock_mult <= 7'h01;
      end else begin
         o_system_clock_mult <= cfg_act_reg.ref_mult_en ? cfg_act_reg.ref_mult_factor : 7'h01;
      end
   end

   // ****************************************
   // Parallel data port
   // ****************************************
   // Word taken in the last high cycle of the data clock, as it falls; burst valid qualifies it
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_mod_word <= '0;
      end else begin
         o_mod_word.valid <= bv_q_reg && (sub_cnt_reg == dscp_pkg::CAPTURE_PHASE);
         if (bv_q_reg && (sub_cnt_reg == dscp_pkg::CAPTURE_PHASE)) begin
            o_mod_word.data <= data_q_reg;
            o_mod_word.fmt  <= fmt_q_reg;
            o_mod_word.dest <= fmt_dest(fmt_q_reg);
         end
      end
   end

   // ****************************************
   // Register read port
   // ****************************************
   dscp_pkg::dscp_status_t status_w;

   always_comb begin
      status_w                   = '0;
      status_w.powerdown_active  = o_powerdown_active;
      status_w.sync_sample_fault = o_sync_sample_fault;
      status_w.ram_sweep_done    = o_ram_sweep_done;
      status_w.pll_locked        = o_pll_locked;
      status_w.profile           = prof_q_reg;
   end

   // Unmapped addresses read as zero; data valid only in the cycle after the strobe
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_rdata <= 32'h0000_0000;
      end else if (i_rd) begin
         if (i_addr == dscp_pkg::ADDR_CFG) begin
            o_rdata <= cfg_stg_reg;
         end else if (i_addr == dscp_pkg::ADDR_STATUS) begin
            o_rdata <= status_w;
         end else if (is_prof_addr(i_addr)) begin
            o_rdata <= prof_stg_reg[i_addr[4:2]];
         end else begin
            o_rdata <= 32'h0000_0000;
         end
      end else begin
         o_rdata <= 32'h0000_0000;
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);

   AST_PROFILE_SELECT: assert property (##1 o_profile_word == $past(prof_act_reg[prof_q_reg]))
      else $error("profile word does not follow selected profile");
   AST_PROFILE_XFER: assert property (prof_change |=> prof_act_reg[7] == $past(prof_stg_reg[7]))
      else $error("profile change did not copy staging buffers");
   AST_COMMIT_XFER: assert property ($rose(commit_q_reg) |=> cfg_act_reg == $past(cfg_stg_reg))
      else $error("commit did not move staged configuration");
   AST_SYNC_CLK_QUARTER: assert property (($rose(o_sync_clk) && !(cfg_act_reg.sync_rx_en && sync_rise))
      |-> (o_sync_clk && !(cfg_act_reg.sync_rx_en && sync_rise))[*2]
      ##1 (!o_sync_clk && !(cfg_act_reg.sync_rx_en && sync_rise))[*2] ##1 o_sync_clk)
      else $error("sync clock is not a quarter-rate square wave");
   AST_RESET_CLEARS: assert property (@(posedge i_clk_sys) disable iff (1'b0)
      i_rst |=> (cfg_act_reg == dscp_pkg::CFG_RST) && !o_ram_sweep_done && !o_mod_word.valid)
      else $error("reset did not restore defaults");
   AST_POWERDOWN: assert property (pd_q_reg |=> o_powerdown_active
      && o_powerdown_mode == $past(cfg_act_reg.pd_mode))
      else $error("power-down request not followed");
   AST_PLL_LOCK: assert property (pll_q_reg |=> o_pll_locked)
      else $error("lock status not shown");
   AST_SWEEP_DONE: assert property (i_ram_sweep_end |-> ##2 o_ram_sweep_done)
      else $error("sweep end not flagged");
   AST_SYNC_FAULT: assert property ((sync_st_reg == SYNC_WAIT && win_cnt_reg == WIN_LAST
      && cfg_act_reg.sync_rx_en && !sync_rise) |-> ##2 o_sync_sample_fault)
      else $error("missing sync not reported");
   AST_SYNC_ALIGN: assert property ((cfg_act_reg.sync_rx_en && sync_rise)
      |=> sub_cnt_reg == dscp_pkg::SUB_ALIGN)
      else $error("subclock not aligned to sync edge");
   AST_SYNC_OUT: assert property ((cfg_act_reg.sync_tx_en && sub_cnt_reg == 2'h0
      && !(cfg_act_reg.sync_rx_en && sync_rise))
      |=> o_sync_out_p && !o_sync_out_n ##1 !o_sync_out_p)
      else $error("sync output pulse wrong");
   AST_PAR_WORD: assert property ((bv_q_reg && sub_cnt_reg == dscp_pkg::CAPTURE_PHASE)
      |=> o_mod_word.valid && o_mod_word.data == $past(data_q_reg) && o_mod_word.fmt == $past(fmt_q_reg))
      else $error("parallel word not captured");
   AST_PAR_STROBE: assert property (o_mod_word.valid |-> $past(sub_cnt_reg) == dscp_pkg::CAPTURE_PHASE)
      else $error("parallel word outside data clock phase");
   AST_FMT_DEST: assert property (o_mod_word.valid |-> o_mod_word.dest == dscp_pkg::dscp_dest_t'(o_mod_word.fmt))
      else $error("format decode wrong");
   AST_MULT_RATIO: assert property ((!cfg_act_reg.ref_mult_en ##1 !cfg_act_reg.ref_mult_en)
      |-> o_system_clock_mult == 7'h01)
      else $error("clock ratio wrong without multiplier");

   CVR_PROFILE_CHANGE: cover property (prof_change ##[1:4] !prof_change);
   CVR_COMMIT: cover property ($rose(commit_q_reg) ##2 (cfg_act_reg != dscp_pkg::CFG_RST));
   CVR_SYNC_RECOVER: cover property (o_sync_sample_fault ##[1:40] !o_sync_sample_fault);
   CVR_BURST: cover property (o_mod_word.valid ##4 o_mod_word.valid);

endmodule
